// ==== src/lshp_consts.svh ====
/*
  Constants of the serial host port: reset mode, counts, bus address.
  Assumes the includer pulls in the types from lshp_pkg separately.
*/
// Behaviour
// R01 - SPI modes accept writes only, no reads
// R02 - Consecutive bytes accepted without any busy handshake
// R03 - 8-bit SPI: MSB first, rising clock edges
// R04 - Chip select enables and resets bit counter
// R05 - Select low means command, high means data
// R06 - Select sampled as clock falls for LSB
// R07 - Back-to-back bytes under one selection are accepted
// R08 - Host keeps 8-bit SPI clock at 8 MHz
// R09 - 3-wire 8-bit: select transition restarts cycle
// R10 - 3-wire 8-bit works with chip select tied
// R11 - 9-bit SPI: select bit, then eight bits
// R12 - Host keeps 9-bit SPI clock at 12 MHz
// R13 - I2C address from pin; header $78-$7F
// R14 - Master opens with START and header byte
// R15 - First byte of a data read is dummy
// R16 - Header fixes direction and content until START
// R17 - Host keeps I2C clock at 4 MHz
// R18 - Mode straps sampled once after reset
// R19 - Acknowledge header and writes; stop on NACK
`ifndef LSHP_CONSTS_SVH
`define LSHP_CONSTS_SVH

// ----------------------------------------------------------------------
// Serial framing
// ----------------------------------------------------------------------
`define LSHP_BYTE_BITS 4'h8
`define LSHP_LAST8 4'h7
`define LSHP_LAST9 4'h8
`define LSHP_I2C_ADDR_HI 5'h0f
`define LSHP_HDR_RW_BIT 0
`define LSHP_HDR_CD_BIT 1
`define LSHP_DUMMY_BYTE 8'h00
`define LSHP_MODE_RESET 2'h0

`endif

// ==== src/lshp_host_port.sv ====
/*
  Serial host port: three SPI variants on the host clock, I2C on the core clock.
  Assumes the straps are static, and that read bytes on RD_DATA_I and
  RD_STATUS_I are presented by core logic on CORE_CLK_I.
*/
`timescale 1ns/10ps
`default_nettype none
`include "lshp_consts.svh"
module lshp_host_port
  import lshp_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic SERIAL_CLK_I,
  input wire logic SERIAL_DATA_I,
  output logic SERIAL_DATA_O,
  output logic SERIAL_DATA_OE_N_O,
  input wire logic CHIP_SELECT_LINE_N_I,
  input wire logic CMD_DATA_SELECT_I,
  input wire logic ADDR_SELECT_PIN_I,
  input wire logic BUS_MODE_STRAP_LO_I,
  input wire logic BUS_MODE_STRAP_HI_I,
  input wire logic [7:0] RD_DATA_I,
  input wire logic [7:0] RD_STATUS_I,
  output lshp_rx_t RX_WORD_O,
  output logic RX_VALID_O,
  output logic RD_TAKE_O,
  output lshp_mode_t BUS_MODE_O
);

  // ----------------------------------------------------------------------
  // Pin synchronisers on the core clock
  // ----------------------------------------------------------------------
  logic scl_s, sda_s, asel_s, strap_hi_s, strap_lo_s, tgl_s;
  logic spi_tgl_q;

  lshp_sync #(.WIDTH(6)) u_core_sync (
    .clk_i(CORE_CLK_I),
    .d_i({SERIAL_CLK_I, SERIAL_DATA_I, ADDR_SELECT_PIN_I,
          BUS_MODE_STRAP_HI_I, BUS_MODE_STRAP_LO_I, spi_tgl_q}),
    .q_o({scl_s, sda_s, asel_s, strap_hi_s, strap_lo_s, tgl_s})
  );

  // ----------------------------------------------------------------------
  // Mode straps
  // ----------------------------------------------------------------------
  // Captured in the first cycle after release so the flop under reset
  // only ever takes a constant.
  logic strap_done_q;
  lshp_mode_t mode_q;

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      strap_done_q <= 1'b0;
      mode_q <= lshp_mode_t'(`LSHP_MODE_RESET);
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      mode_q <= lshp_mode_t'({strap_hi_s, strap_lo_s}); // [R18]
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      BUS_MODE_O <= lshp_mode_t'(`LSHP_MODE_RESET);
    end else begin
      BUS_MODE_O <= mode_q;
    end
  end

  wire logic is_i2c = (mode_q == LSHP_I2C);

  // ----------------------------------------------------------------------
  // SPI receiver on the host serial clock
  // ----------------------------------------------------------------------
  // Chip select high clears the cycle at once, with no clock edge needed;
  // tying it low leaves framing to the clock and select lines alone.
  wire logic spi_clr = CHIP_SELECT_LINE_N_I; // [R04] [R10]
  logic [1:0] spi_mode_s;
  logic [3:0] spi_cnt_q;
  logic [7:0] spi_sh_q;
  logic [7:0] spi_byte_q;
  logic spi_byte_cd_q, spi_cd9_q, spi_cd_last_q, spi_cd_neg_q;

  // The mode is read directly: it is fixed one core cycle after reset, long
  // before any host traffic, and a synchroniser on the burst-only serial
  // clock would still show the old mode for the first bits of a byte.
  assign spi_mode_s = mode_q;

  wire logic spi_nine = (spi_mode_s == LSHP_SPI3_9);
  wire logic spi_cd_edge = (spi_mode_s == LSHP_SPI3_8) &&
                           (CMD_DATA_SELECT_I != spi_cd_last_q);
  wire logic [3:0] spi_cnt_eff = spi_cd_edge ? 4'h0 : spi_cnt_q; // [R09]
  wire logic [3:0] spi_last = spi_nine ? `LSHP_LAST9 : `LSHP_LAST8;
  wire logic spi_done = (spi_cnt_eff == spi_last);

  // Select is taken as the clock falls ahead of the last bit's rise.
  always_ff @(negedge SERIAL_CLK_I or posedge spi_clr) begin
    if (spi_clr) begin
      spi_cd_neg_q <= 1'b0;
    end else if (spi_cnt_q == `LSHP_LAST8) begin
      spi_cd_neg_q <= CMD_DATA_SELECT_I; // [R06]
    end
  end

  always_ff @(posedge SERIAL_CLK_I or posedge spi_clr) begin
    if (spi_clr) begin
      spi_cnt_q <= 4'h0;
      spi_sh_q <= 8'h00;
      spi_cd9_q <= 1'b0;
    end else begin
      if (spi_nine && spi_cnt_eff == 4'h0) begin
        spi_cd9_q <= SERIAL_DATA_I; // [R11]
      end else begin
        spi_sh_q <= {spi_sh_q[6:0], SERIAL_DATA_I}; // [R03]
      end
      // Wrapping to zero lets the next byte follow with no gap.
      spi_cnt_q <= spi_done ? 4'h0 : spi_cnt_eff + 4'h1; // [R07] [R02]
    end
  end

  // Previous select level is kept across chip select so that tying
  // chip select low does not mask a select transition.
  always_ff @(posedge SERIAL_CLK_I) begin
    spi_cd_last_q <= CMD_DATA_SELECT_I;
  end

  // Holding register and toggle: the byte stays still for at least eight
  // serial clocks, far longer than the core needs to take it.
  always_ff @(posedge SERIAL_CLK_I) begin
    if (spi_done && !spi_clr) begin
      spi_byte_q <= {spi_sh_q[6:0], SERIAL_DATA_I}; // [R03]
      spi_byte_cd_q <= spi_nine ? spi_cd9_q : spi_cd_neg_q; // [R05] [R11]
    end
  end

  // The toggle is cleared by the core reset, not by chip select, so that
  // deselection never shows the core a byte that did not arrive.
  always_ff @(posedge SERIAL_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      spi_tgl_q <= 1'b0;
    end else if (spi_done && !spi_clr) begin
      spi_tgl_q <= ~spi_tgl_q;
    end
  end

  // ----------------------------------------------------------------------
  // I2C slave on the core clock
  // ----------------------------------------------------------------------
  logic scl_p_q, sda_p_q;
  lshp_i2c_st_t st_q;
  logic [3:0] i2c_cnt_q;
  logic [7:0] i2c_sh_q;
  logic [1:0] hdr_q;
  logic i2c_wr_q;
  logic [7:0] i2c_wr_byte_q;
  logic i2c_take_q;

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  wire logic scl_rise = scl_s && !scl_p_q;
  wire logic scl_fall = !scl_s && scl_p_q;
  wire logic i2c_start = scl_s && scl_p_q && sda_p_q && !sda_s;
  wire logic i2c_stop = scl_s && scl_p_q && !sda_p_q && sda_s;
  wire logic hdr_match = (i2c_sh_q[7:2] == {`LSHP_I2C_ADDR_HI, asel_s});

  function automatic logic [7:0] rd_byte(input logic is_data,
                                         input logic first,
                                         input logic [7:0] data,
                                         input logic [7:0] status);
    if (!is_data) begin
      rd_byte = status;
    end else if (first) begin
      rd_byte = `LSHP_DUMMY_BYTE; // [R15]
    end else begin
      rd_byte = data;
    end
  endfunction : rd_byte

  wire logic [7:0] rd_first = rd_byte(hdr_q[`LSHP_HDR_CD_BIT], 1'b1,
                                      RD_DATA_I, RD_STATUS_I);
  wire logic [7:0] rd_next = rd_byte(hdr_q[`LSHP_HDR_CD_BIT], 1'b0,
                                     RD_DATA_I, RD_STATUS_I);

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      st_q <= I2C_IDLE;
      i2c_cnt_q <= 4'h0;
      i2c_sh_q <= 8'h00;
      hdr_q <= 2'b00;
      SERIAL_DATA_OE_N_O <= 1'b1;
      i2c_wr_q <= 1'b0;
      i2c_wr_byte_q <= 8'h00;
      i2c_take_q <= 1'b0;
    end else begin
      i2c_wr_q <= 1'b0;
      i2c_take_q <= 1'b0;
      if (!is_i2c) begin
        st_q <= I2C_IDLE;
        SERIAL_DATA_OE_N_O <= 1'b1; // [R01]
      end else if (i2c_start) begin
        st_q <= I2C_ADDR; // [R14] [R16]
        i2c_cnt_q <= 4'h0;
        SERIAL_DATA_OE_N_O <= 1'b1;
      end else if (i2c_stop) begin
        st_q <= I2C_IDLE;
        SERIAL_DATA_OE_N_O <= 1'b1;
      end else begin
        case (st_q)
          I2C_ADDR, I2C_WR: begin
            if (scl_rise) begin
              i2c_sh_q <= {i2c_sh_q[6:0], sda_s};
              i2c_cnt_q <= i2c_cnt_q + 4'h1;
            end else if (scl_fall && i2c_cnt_q == `LSHP_BYTE_BITS) begin
              i2c_cnt_q <= 4'h0;
              if (st_q == I2C_WR) begin
                i2c_wr_q <= 1'b1;
                i2c_wr_byte_q <= i2c_sh_q;
                SERIAL_DATA_OE_N_O <= 1'b0; // [R19]
                st_q <= I2C_WACK;
              end else if (hdr_match) begin
                hdr_q <= i2c_sh_q[1:0]; // [R13] [R16]
                SERIAL_DATA_OE_N_O <= 1'b0; // [R19]
                st_q <= I2C_AACK;
              end else begin
                st_q <= I2C_SKIP;
              end
            end
          end
          I2C_AACK: begin
            if (scl_fall) begin
              i2c_cnt_q <= 4'h0;
              if (hdr_q[`LSHP_HDR_RW_BIT]) begin
                i2c_sh_q <= rd_first; // [R15]
                SERIAL_DATA_OE_N_O <= rd_first[7];
                i2c_take_q <= !hdr_q[`LSHP_HDR_CD_BIT];
                st_q <= I2C_RD;
              end else begin
                SERIAL_DATA_OE_N_O <= 1'b1;
                st_q <= I2C_WR;
              end
            end
          end
          I2C_WACK: begin
            if (scl_fall) begin
              SERIAL_DATA_OE_N_O <= 1'b1;
              st_q <= I2C_WR;
            end
          end
          I2C_RD: begin
            if (scl_fall) begin
              if (i2c_cnt_q == `LSHP_LAST8) begin
                SERIAL_DATA_OE_N_O <= 1'b1;
                i2c_cnt_q <= 4'h0;
                st_q <= I2C_RACK;
              end else begin
                i2c_sh_q <= {i2c_sh_q[6:0], 1'b0};
                SERIAL_DATA_OE_N_O <= i2c_sh_q[6];
                i2c_cnt_q <= i2c_cnt_q + 4'h1;
              end
            end
          end
          I2C_RACK: begin
            if (scl_rise && sda_s) begin
              st_q <= I2C_SKIP; // [R19]
            end else if (scl_fall) begin
              i2c_sh_q <= rd_next;
              SERIAL_DATA_OE_N_O <= rd_next[7];
              i2c_take_q <= 1'b1;
              st_q <= I2C_RD;
            end
          end
          default: begin
            SERIAL_DATA_OE_N_O <= 1'b1;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Received byte output, shared by all modes
  // ----------------------------------------------------------------------
  logic tgl_p_q;
  wire logic spi_new = (tgl_s != tgl_p_q) && !is_i2c;

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      tgl_p_q <= 1'b0;
      RX_VALID_O <= 1'b0;
      RX_WORD_O <= '0;
      RD_TAKE_O <= 1'b0;
      SERIAL_DATA_O <= 1'b0;
    end else begin
      tgl_p_q <= tgl_s;
      RD_TAKE_O <= i2c_take_q;
      SERIAL_DATA_O <= 1'b0;
      RX_VALID_O <= spi_new || i2c_wr_q; // [R02]
      if (spi_new) begin
        RX_WORD_O <= '{is_data: spi_byte_cd_q, data: spi_byte_q}; // [R05]
      end else if (i2c_wr_q) begin
        RX_WORD_O <= '{is_data: hdr_q[`LSHP_HDR_CD_BIT], data: i2c_wr_byte_q}; // [R16]
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_byte_end;
    spi_done;
  endsequence

  sequence s_tgl_flip;
    spi_tgl_q != $past(spi_tgl_q);
  endsequence

  a_spi_byte_end: assert property (@(posedge SERIAL_CLK_I) disable iff (spi_clr) // [R03]
    s_byte_end |=> s_tgl_flip ##0 spi_cnt_q == 4'h0)
    else $error("byte end did not publish the byte");

  a_spi_cd_restart: assert property (@(posedge SERIAL_CLK_I) disable iff (spi_clr) // [R09]
    spi_cd_edge |=> spi_cnt_q == 4'h1)
    else $error("select transition did not restart the cycle");

  a_spi_cnt_range: assert property (@(posedge SERIAL_CLK_I) disable iff (spi_clr) // [R11]
    spi_cnt_q <= (spi_nine ? `LSHP_LAST9 : `LSHP_LAST8))
    else $error("bit counter ran past the last bit");

  a_spi_no_drive: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [R01]
    !is_i2c |=> SERIAL_DATA_OE_N_O)
    else $error("data pin driven outside I2C mode");

  a_rx_from_tgl: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [R05]
    spi_new |=> RX_VALID_O && RX_WORD_O.data == $past(spi_byte_q))
    else $error("SPI byte not delivered");

  a_rx_one_pulse: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [R02]
    RX_VALID_O |=> !RX_VALID_O)
    else $error("receive strobe longer than one cycle");

  a_mode_static: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [R18]
    strap_done_q |=> $stable(mode_q))
    else $error("mode changed after capture");

  a_hdr_ack: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [R13]
    is_i2c && st_q == I2C_ADDR && scl_fall && i2c_cnt_q == `LSHP_BYTE_BITS
      && hdr_match && !i2c_start && !i2c_stop
      |=> st_q == I2C_AACK && !SERIAL_DATA_OE_N_O)
    else $error("matching header not acknowledged");

  a_dummy_no_take: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [R15]
    is_i2c && st_q == I2C_AACK && scl_fall && hdr_q == 2'b11
      && !i2c_start && !i2c_stop |=> !i2c_take_q ##1 !RD_TAKE_O)
    else $error("dummy byte consumed read data");

  a_nack_stop: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [R19]
    is_i2c && st_q == I2C_RACK && scl_rise && sda_s && !i2c_stop
      |=> st_q == I2C_SKIP && SERIAL_DATA_OE_N_O)
    else $error("not-acknowledge did not end the read");

  a_start_hdr: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [R14]
    is_i2c && i2c_start |=> st_q == I2C_ADDR && i2c_cnt_q == 4'h0)
    else $error("START did not open a header");

endmodule : lshp_host_port
`default_nettype wire

// ==== src/lshp_pkg.sv ====
/*
  Types of the serial host port.
  Assumes nothing of its surroundings.
*/
package lshp_pkg;

  typedef enum logic [1:0] {
    LSHP_SPI4_8 = 2'b00,
    LSHP_SPI3_8 = 2'b01,
    LSHP_SPI3_9 = 2'b10,
    LSHP_I2C = 2'b11
  } lshp_mode_t;

  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_ADDR = 3'b001,
    I2C_AACK = 3'b010,
    I2C_WR = 3'b011,
    I2C_WACK = 3'b100,
    I2C_RD = 3'b101,
    I2C_RACK = 3'b110,
    I2C_SKIP = 3'b111
  } lshp_i2c_st_t;

  typedef struct packed {
    logic is_data;
    logic [7:0] data;
  } lshp_rx_t;

endpackage : lshp_pkg

// ==== src/lshp_sync.sv ====
/*
  Two-flop level synchroniser of parameterised width.
  Assumes each bit is a slow level or a toggle; words are not made coherent.
*/
`timescale 1ns/10ps
`default_nettype none
module lshp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_i) begin
    meta_q <= d_i;
    q_o <= meta_q;
  end

endmodule : lshp_sync
`default_nettype wire

// ==== test/lshp_host_model.sv ====
/*
  Host model: writes bytes over SPI and acts as I2C master with a pull-up on the data wire.
  Assumes the device enable is low while the device pulls the data wire.
*/
`timescale 1ns/10ps
`default_nettype none
module lshp_host_model (
  input wire logic dev_oe_n_i,
  output logic sclk_o,
  output logic sdi_o,
  output logic cs_n_o,
  output logic cds_o
);
  // ----------------------------------------------------------------------
  // Serial timing
  // ----------------------------------------------------------------------
  // A phase is one 80 ns link period; SPI runs at 6.25 MHz and I2C at 3.1 MHz.
  localparam int Q = 80;
  logic spi_q = 1'b0;
  logic pull_q = 1'b0;
  logic i2c_q = 1'b0;
  assign sdi_o = i2c_q ? ~(pull_q | ~dev_oe_n_i) : spi_q;
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    cds_o = 1'b0;
  end
  task automatic cs(input logic v);
    cs_n_o = v;
    #(Q + 13);
  endtask : cs
  // A released data line shows the inverse, so a stale bit is never taken for a good one.
  task automatic spi_word(input logic [8:0] v, input int n, input logic cd);
    i2c_q = 1'b0;
    cds_o = cd;
    // Data moves with the falling edge, never in the step of a sampling rise.
    for (int i = n - 1; i >= 0; i--) begin
      #Q sclk_o = 1'b0;
      spi_q = v[i];
      #Q sclk_o = 1'b1;
    end
    #Q spi_q = ~spi_q;
  endtask : spi_word
  task automatic i2c_bit(input logic b, output logic s);
    pull_q = ~b;
    #Q sclk_o = 1'b1;
    #(2 * Q) s = sdi_o;
    sclk_o = 1'b0;
    #Q;
  endtask : i2c_bit
  task automatic i2c_start();
    i2c_q = 1'b1;
    pull_q = 1'b0;
    #Q pull_q = 1'b1;
    #Q sclk_o = 1'b0;
    #Q;
  endtask : i2c_start
  task automatic i2c_stop();
    pull_q = 1'b1;
    #Q sclk_o = 1'b1;
    #Q pull_q = 1'b0;
    #Q;
  endtask : i2c_stop
  task automatic i2c_wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) i2c_bit(d[i], s);
    i2c_bit(1'b1, s);
    ack = ~s;
  endtask : i2c_wbyte
  task automatic i2c_rbyte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) i2c_bit(1'b1, d[i]);
    i2c_bit(nack, s);
  endtask : i2c_rbyte
endmodule : lshp_host_model
`default_nettype wire

// ==== test/lshp_host_port_bench.sv ====
/*
  Self-checking bench of the serial host port: SPI rows in a loop, then I2C and abort cases.
  Assumes the host model file is compiled beside it.
*/
`timescale 1ns/10ps
`default_nettype none
module lshp_host_port_bench
  import lshp_pkg::*;
;
  typedef struct {logic [1:0] m; logic cd; logic [7:0] d;} lshp_row_t;
  logic core_clk = 1'b0;
  logic rst_n;
  logic [1:0] strap;
  logic addr_sel;
  logic [7:0] rd_data;
  logic [7:0] rd_status;
  logic sclk, sdi, cs_n, cds, sdo, oe_n, rx_valid, rd_take, ack;
  logic [7:0] rb;
  lshp_rx_t rx_word;
  lshp_mode_t bus_mode;
  lshp_rx_t rxq[$];
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  int takes = 0;
  int spi_drive = 0;
  lshp_row_t rows [6] = '{'{2'h0, 1'b0, 8'ha5}, '{2'h0, 1'b1, 8'h3c}, '{2'h1, 1'b0, 8'h81},
    '{2'h1, 1'b1, 8'h7e}, '{2'h2, 1'b0, 8'hc3}, '{2'h2, 1'b1, 8'h18}};
  always #4 core_clk = ~core_clk;
  lshp_host_model HOST (.dev_oe_n_i(oe_n), .sclk_o(sclk), .sdi_o(sdi), .cs_n_o(cs_n),
    .cds_o(cds));
  lshp_host_port DUT (.CORE_CLK_I(core_clk), .RST_N_I(rst_n), .SERIAL_CLK_I(sclk),
    .SERIAL_DATA_I(sdi), .SERIAL_DATA_O(sdo), .SERIAL_DATA_OE_N_O(oe_n),
    .CHIP_SELECT_LINE_N_I(cs_n), .CMD_DATA_SELECT_I(cds), .ADDR_SELECT_PIN_I(addr_sel),
    .BUS_MODE_STRAP_LO_I(strap[0]), .BUS_MODE_STRAP_HI_I(strap[1]), .RD_DATA_I(rd_data),
    .RD_STATUS_I(rd_status), .RX_WORD_O(rx_word), .RX_VALID_O(rx_valid),
    .RD_TAKE_O(rd_take), .BUS_MODE_O(bus_mode));
  // ----------------------------------------------------------------------
  // Monitor and report
  // ----------------------------------------------------------------------
  always @(posedge core_clk) begin
    cyc++;
    if (rx_valid === 1'b1) rxq.push_back(rx_word);
    if (rd_take === 1'b1) takes++;
    if (rst_n === 1'b1 && bus_mode !== LSHP_I2C && oe_n !== 1'b1) spi_drive++;
    if (cyc == 40000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  task automatic do_reset(input logic [1:0] m);
    @(posedge core_clk);
    rst_n <= 1'b0;
    strap <= m;
    repeat (8) @(posedge core_clk);
    #1 check("reset_word", rx_word, 9'h000);
    check("reset_pins", {5'h00, oe_n, rx_valid, rd_take, sdo}, 9'h008);
    @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    strap <= ~m;
    repeat (6) @(posedge core_clk);
    check("bus_mode", {7'h00, bus_mode}, {7'h00, m});
    rxq.delete();
  endtask : do_reset
  task automatic expect_rx(input lshp_rx_t exp);
    for (int i = 0; i < 400 && rxq.size() == 0; i++) @(posedge core_clk);
    if (rxq.size() == 0) check("rx_missing", 9'h1ff, exp);
    else check("rx_word", rxq.pop_front(), exp);
  endtask : expect_rx
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_n <= 1'b0;
    strap <= 2'h0;
    addr_sel <= 1'b0;
    rd_data <= 8'h00;
    rd_status <= 8'h00;
    foreach (rows[i]) begin
      if (i % 2 == 0) do_reset(rows[i].m);
      HOST.cs(1'b0);
      if (rows[i].m == 2'h2) HOST.spi_word({rows[i].cd, rows[i].d}, 9, 1'b0);
      else HOST.spi_word({1'b0, rows[i].d}, 8, rows[i].cd);
      HOST.cs(1'b1);
      expect_rx({rows[i].cd, rows[i].d});
    end
    do_reset(2'h0);
    HOST.cs(1'b0);
    HOST.spi_word(9'h00f, 4, 1'b1);
    HOST.cs(1'b1);
    HOST.cs(1'b0);
    HOST.spi_word(9'h05a, 8, 1'b1);
    HOST.spi_word(9'h012, 8, 1'b0);
    HOST.cs(1'b1);
    expect_rx({1'b1, 8'h5a});
    expect_rx({1'b0, 8'h12});
    do_reset(2'h1);
    HOST.cs(1'b0);
    HOST.spi_word(9'h005, 3, 1'b0);
    HOST.spi_word(9'h096, 8, 1'b1);
    HOST.spi_word(9'h069, 8, 1'b1);
    expect_rx({1'b1, 8'h96});
    expect_rx({1'b1, 8'h69});
    HOST.cs(1'b1);
    check("spi_read_drive", 9'(spi_drive), 9'h000);
    do_reset(2'h3);
    HOST.i2c_start();
    HOST.i2c_wbyte(8'h7a, ack);
    check("ack_hdr", {8'h00, ack}, 9'h001);
    HOST.i2c_wbyte(8'hd4, ack);
    check("ack_wr", {8'h00, ack}, 9'h001);
    HOST.i2c_stop();
    expect_rx({1'b1, 8'hd4});
    HOST.i2c_start();
    HOST.i2c_wbyte(8'h78, ack);
    HOST.i2c_wbyte(8'h2b, ack);
    HOST.i2c_stop();
    expect_rx({1'b0, 8'h2b});
    @(posedge core_clk);
    rd_data <= 8'h5c;
    rd_status <= 8'he1;
    takes = 0;
    HOST.i2c_start();
    HOST.i2c_wbyte(8'h7b, ack);
    HOST.i2c_rbyte(1'b0, rb);
    check("dummy", {1'b0, rb}, 9'h000);
    HOST.i2c_rbyte(1'b1, rb);
    check("rd_data", {1'b0, rb}, 9'h05c);
    HOST.i2c_stop();
    check("takes", 9'(takes), 9'h001);
    takes = 0;
    HOST.i2c_start();
    HOST.i2c_wbyte(8'h79, ack);
    HOST.i2c_rbyte(1'b1, rb);
    HOST.i2c_stop();
    check("rd_status", {1'b0, rb}, 9'h0e1);
    check("status_takes", 9'(takes), 9'h001);
    HOST.i2c_start();
    HOST.i2c_wbyte(8'h7c, ack);
    HOST.i2c_stop();
    check("nack_other", {8'h00, ack}, 9'h000);
    @(posedge core_clk);
    addr_sel <= 1'b1;
    repeat (6) @(posedge core_clk);
    HOST.i2c_start();
    HOST.i2c_wbyte(8'h7e, ack);
    HOST.i2c_wbyte(8'h33, ack);
    HOST.i2c_stop();
    check("ack_hi", {8'h00, ack}, 9'h001);
    expect_rx({1'b1, 8'h33});
    check("rx_extra", 9'(rxq.size()), 9'h000);
    tally_and_finish();
  end
endmodule : lshp_host_port_bench
`default_nettype wire
